// ==== lgm_top.sv ====
// Overview of operation
// [RULE1] gate one select: in4 high pair, in1 low
// [RULE2] gate two select: same pair mapping
// [RULE3] gate three select: same pair mapping
// [RULE4] gate four select: same pair mapping
// [RULE5] select one includes signal, zero excludes
// [RULE6] each input has true and inverted copy
// [RULE7] selects read/write, kept over ordinary reset
// [RULE8] gate polarity bit inverts gate output
// [RULE9] five bit source field per input
// [RULE10] three bit function mode field
// [RULE11] gate ors selections, zero when none
//
// Purpose: gate input matrix of a configurable logic cell with AHB-Lite registers
// Assumes: source and data inputs synchronous to mclk; single word transfers
// Notes:   por_n clears config; rst leaves select and config bits untouched
//
// Local design decisions: the AHB-Lite register port and the address map.
`timescale 1ns/100ps
`default_nettype none
module lgm_top
  import lgm_pkg::*;
#(
  parameter int unsigned SOURCES = NUM_SOURCES
) (
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire logic               por_n,
  input  wire logic [SOURCES-1:0] sources,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic                    gate_one_out,
  output logic                    gate_two_out,
  output logic                    gate_three_out,
  output logic                    gate_four_out,
  output logic [MODE_WIDTH-1:0]   cell_function_sel
);
  logic [SEL_WIDTH-1:0]     gate_one_input_select;
  logic [SEL_WIDTH-1:0]     gate_two_input_select;
  logic [SEL_WIDTH-1:0]     gate_three_input_select;
  logic [SEL_WIDTH-1:0]     gate_four_input_select;
  logic                     gate_one_invert;
  logic                     gate_two_invert;
  logic                     gate_three_invert;
  logic                     gate_four_invert;
  logic [SRC_SEL_WIDTH-1:0] input_one_source_sel;
  logic [SRC_SEL_WIDTH-1:0] input_two_source_sel;
  logic [SRC_SEL_WIDTH-1:0] input_three_source_sel;
  logic [SRC_SEL_WIDTH-1:0] input_four_source_sel;
  logic [MODE_WIDTH-1:0]    mode_reg;
  logic [NUM_INPUTS-1:0]    data_in;
  logic [NUM_INPUTS-1:0]    data_true;
  logic [NUM_INPUTS-1:0]    data_inv;
  logic [SEL_WIDTH-1:0]     signals;
  logic [NUM_GATES-1:0]     gate_raw;
  logic [NUM_GATES-1:0]     gate_pol;
  logic [NUM_GATES-1:0]     gate_status;
  lgm_access_type           pending;
  logic                     next_access;
  logic [31:0]              next_rdata;

  // [RULE9] source multiplexers
  always_comb begin
    data_in[0] = sources[input_one_source_sel];
    data_in[1] = sources[input_two_source_sel];
    data_in[2] = sources[input_three_source_sel];
    data_in[3] = sources[input_four_source_sel];
  end

  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_pair
    lgm_input_pair u_pair (
      .data_in      (data_in[i]),
      .true_out     (data_true[i]),
      .inverted_out (data_inv[i])
    );
  end

  // [RULE1] pair mapping of select bits
  always_comb begin
    signals[IN4_TRUE_BIT] = data_true[3];
    signals[IN4_INV_BIT]  = data_inv[3];
    signals[IN3_TRUE_BIT] = data_true[2];
    signals[IN3_INV_BIT]  = data_inv[2];
    signals[IN2_TRUE_BIT] = data_true[1];
    signals[IN2_INV_BIT]  = data_inv[1];
    signals[IN1_TRUE_BIT] = data_true[0];
    signals[IN1_INV_BIT]  = data_inv[0];
  end

  lgm_gate u_gate_one (
    .select   (gate_one_input_select),
    .signals  (signals),
    .invert   (gate_one_invert),
    .raw_out  (gate_raw[0]),
    .gate_out (gate_pol[0])
  );
  // [RULE2] gate two uses same mapping
  lgm_gate u_gate_two (
    .select   (gate_two_input_select),
    .signals  (signals),
    .invert   (gate_two_invert),
    .raw_out  (gate_raw[1]),
    .gate_out (gate_pol[1])
  );
  // [RULE3] gate three uses same mapping
  lgm_gate u_gate_three (
    .select   (gate_three_input_select),
    .signals  (signals),
    .invert   (gate_three_invert),
    .raw_out  (gate_raw[2]),
    .gate_out (gate_pol[2])
  );
  // [RULE4] gate four uses same mapping
  lgm_gate u_gate_four (
    .select   (gate_four_input_select),
    .signals  (signals),
    .invert   (gate_four_invert),
    .raw_out  (gate_raw[3]),
    .gate_out (gate_pol[3])
  );

  always_ff @(posedge mclk) begin
    if (rst) begin
      gate_one_out   <= 1'b0;
      gate_two_out   <= 1'b0;
      gate_three_out <= 1'b0;
      gate_four_out  <= 1'b0;
      gate_status    <= '0;
    end else begin
      gate_one_out   <= gate_pol[0];
      gate_two_out   <= gate_pol[1];
      gate_three_out <= gate_pol[2];
      gate_four_out  <= gate_pol[3];
      gate_status    <= gate_raw;
    end
  end

  // bus address phase capture
  assign next_access = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);

  always_ff @(posedge mclk) begin
    if (rst) begin
      pending <= '0;
    end else if (hready) begin
      pending.sel   <= next_access;
      pending.write <= hwrite;
      pending.addr  <= haddr[11:0];
    end
  end

  // [RULE7] selects survive rst, cleared only at power on
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      gate_one_input_select   <= SEL_POWER_ON_VALUE;
      gate_two_input_select   <= SEL_POWER_ON_VALUE;
      gate_three_input_select <= SEL_POWER_ON_VALUE;
      gate_four_input_select  <= SEL_POWER_ON_VALUE;
    end else if (pending.sel && pending.write) begin
      unique case (pending.addr)
        GATE_ONE_SEL_OFFSET:   gate_one_input_select   <= hwdata[SEL_WIDTH-1:0];
        GATE_TWO_SEL_OFFSET:   gate_two_input_select   <= hwdata[SEL_WIDTH-1:0];
        GATE_THREE_SEL_OFFSET: gate_three_input_select <= hwdata[SEL_WIDTH-1:0];
        GATE_FOUR_SEL_OFFSET:  gate_four_input_select  <= hwdata[SEL_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // [RULE8] polarity bits
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      {gate_four_invert, gate_three_invert, gate_two_invert, gate_one_invert} <= INVERT_POWER_ON_VALUE;
    end else if (pending.sel && pending.write && pending.addr == GATE_INVERT_OFFSET) begin
      {gate_four_invert, gate_three_invert, gate_two_invert, gate_one_invert} <= hwdata[NUM_GATES-1:0];
    end
  end

  // [RULE9] source select fields
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      input_one_source_sel   <= SOURCE_POWER_ON_VALUE;
      input_two_source_sel   <= SOURCE_POWER_ON_VALUE;
      input_three_source_sel <= SOURCE_POWER_ON_VALUE;
      input_four_source_sel  <= SOURCE_POWER_ON_VALUE;
    end else if (pending.sel && pending.write) begin
      unique case (pending.addr)
        SOURCE_ONE_OFFSET:   input_one_source_sel   <= hwdata[SRC_SEL_WIDTH-1:0];
        SOURCE_TWO_OFFSET:   input_two_source_sel   <= hwdata[SRC_SEL_WIDTH-1:0];
        SOURCE_THREE_OFFSET: input_three_source_sel <= hwdata[SRC_SEL_WIDTH-1:0];
        SOURCE_FOUR_OFFSET:  input_four_source_sel  <= hwdata[SRC_SEL_WIDTH-1:0];
        default: begin
        end
      endcase
    end
  end

  // [RULE10] function mode field
  always_ff @(posedge mclk) begin
    if (!por_n) begin
      mode_reg <= MODE_POWER_ON_VALUE;
    end else if (pending.sel && pending.write && pending.addr == FUNCTION_OFFSET) begin
      mode_reg <= hwdata[MODE_WIDTH-1:0];
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      cell_function_sel <= MODE_POWER_ON_VALUE;
    end else begin
      cell_function_sel <= mode_reg;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (haddr[11:0])
      GATE_ONE_SEL_OFFSET:   next_rdata[SEL_WIDTH-1:0] = gate_one_input_select;
      GATE_TWO_SEL_OFFSET:   next_rdata[SEL_WIDTH-1:0] = gate_two_input_select;
      GATE_THREE_SEL_OFFSET: next_rdata[SEL_WIDTH-1:0] = gate_three_input_select;
      GATE_FOUR_SEL_OFFSET:  next_rdata[SEL_WIDTH-1:0] = gate_four_input_select;
      GATE_INVERT_OFFSET:    next_rdata[NUM_GATES-1:0] =
        {gate_four_invert, gate_three_invert, gate_two_invert, gate_one_invert};
      SOURCE_ONE_OFFSET:     next_rdata[SRC_SEL_WIDTH-1:0] = input_one_source_sel;
      SOURCE_TWO_OFFSET:     next_rdata[SRC_SEL_WIDTH-1:0] = input_two_source_sel;
      SOURCE_THREE_OFFSET:   next_rdata[SRC_SEL_WIDTH-1:0] = input_three_source_sel;
      SOURCE_FOUR_OFFSET:    next_rdata[SRC_SEL_WIDTH-1:0] = input_four_source_sel;
      FUNCTION_OFFSET:       next_rdata[MODE_WIDTH-1:0] = mode_reg;
      GATE_STATUS_OFFSET:    next_rdata[NUM_GATES-1:0] = gate_status;
      default:               next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (next_access && !hwrite) begin
      hrdata <= next_rdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== lgm_pkg.sv ====
// Purpose: constants and types for the logic cell gate input matrix
// Assumes: AHB-Lite register bus, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses
`default_nettype none
package lgm_pkg;
  localparam int unsigned NUM_GATES        = 4;
  localparam int unsigned NUM_INPUTS       = 4;
  localparam int unsigned SEL_WIDTH        = 8;
  localparam int unsigned SRC_SEL_WIDTH    = 5;
  localparam int unsigned MODE_WIDTH       = 3;
  localparam int unsigned NUM_SOURCES      = 32;

  localparam logic [11:0] GATE_ONE_SEL_OFFSET   = 12'h000;
  localparam logic [11:0] GATE_TWO_SEL_OFFSET   = 12'h004;
  localparam logic [11:0] GATE_THREE_SEL_OFFSET = 12'h008;
  localparam logic [11:0] GATE_FOUR_SEL_OFFSET  = 12'h00c;
  localparam logic [11:0] GATE_INVERT_OFFSET    = 12'h010;
  localparam logic [11:0] SOURCE_ONE_OFFSET     = 12'h014;
  localparam logic [11:0] SOURCE_TWO_OFFSET     = 12'h018;
  localparam logic [11:0] SOURCE_THREE_OFFSET   = 12'h01c;
  localparam logic [11:0] SOURCE_FOUR_OFFSET    = 12'h020;
  localparam logic [11:0] FUNCTION_OFFSET       = 12'h024;
  localparam logic [11:0] GATE_STATUS_OFFSET    = 12'h028;

  localparam logic [7:0] SEL_POWER_ON_VALUE    = 8'h00;
  localparam logic [3:0] INVERT_POWER_ON_VALUE = 4'h0;
  localparam logic [4:0] SOURCE_POWER_ON_VALUE = 5'h00;
  localparam logic [2:0] MODE_POWER_ON_VALUE   = 3'h0;

  // bit pair positions inside each select register
  localparam int unsigned IN1_INV_BIT  = 0;
  localparam int unsigned IN1_TRUE_BIT = 1;
  localparam int unsigned IN2_INV_BIT  = 2;
  localparam int unsigned IN2_TRUE_BIT = 3;
  localparam int unsigned IN3_INV_BIT  = 4;
  localparam int unsigned IN3_TRUE_BIT = 5;
  localparam int unsigned IN4_INV_BIT  = 6;
  localparam int unsigned IN4_TRUE_BIT = 7;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;

  typedef enum logic [2:0] {
    lgm_and_or_type_val, lgm_or_xor_val, lgm_and4_val, lgm_sr_latch_val,
    lgm_dff_sr_val, lgm_dff2_r_val, lgm_jk_r_val, lgm_tlatch_val
  } lgm_mode_type;

  typedef struct packed {
    logic       sel;
    logic       write;
    logic [11:0] addr;
  } lgm_access_type;
endpackage
`default_nettype wire

// ==== lgm_input_pair.sv ====
// Purpose: true and inverted copy of one data input
// Assumes: data already synchronous to mclk
// Notes:   purely combinational
`timescale 1ns/100ps
`default_nettype none
module lgm_input_pair (
  input  wire logic data_in,
  output logic      true_out,
  output logic      inverted_out
);
  // [RULE6] true and complement
  assign true_out     = data_in;
  assign inverted_out = ~data_in;
endmodule
`default_nettype wire

// ==== lgm_gate.sv ====
// Purpose: one selection gate of the matrix
// Assumes: select layout input four true at the top down to input one inverted
// Notes:   output is registered by the parent
`timescale 1ns/100ps
`default_nettype none
module lgm_gate
  import lgm_pkg::*;
#(
  parameter int unsigned WIDTH = SEL_WIDTH
) (
  input  wire logic [WIDTH-1:0] select,
  input  wire logic [WIDTH-1:0] signals,
  input  wire logic             invert,
  output logic                  raw_out,
  output logic                  gate_out
);
  // [RULE5] select bit gates signal
  // [RULE11] or of selected, zero if none
  assign raw_out  = |(select & signals);
  // [RULE8] per gate polarity
  assign gate_out = raw_out ^ invert;
endmodule
`default_nettype wire

// ==== lgm_checker.sv ====
// Purpose: bus and gate output timing checks for lgm_top
// Assumes: zero wait state slave, single word transfers
// Notes:   bound to lgm_top below
`timescale 1ns/100ps
`default_nettype none
module lgm_checker
  import lgm_pkg::*;
#(
  parameter int unsigned SOURCES = NUM_SOURCES
) (
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  por_n,
  input wire logic [SOURCES-1:0]    sources,
  input wire logic                  hsel,
  input wire logic [31:0]           haddr,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic [31:0]           hwdata,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire logic                  gate_one_out,
  input wire logic                  gate_two_out,
  input wire logic                  gate_three_out,
  input wire logic                  gate_four_out,
  input wire logic [MODE_WIDTH-1:0] cell_function_sel
);
  logic       taken;
  logic       wr_data;
  logic [3:0] gates;
  assign taken = hsel && hready && htrans[1];
  assign gates = {gate_four_out, gate_three_out, gate_two_out, gate_one_out};
  always_ff @(posedge mclk) begin
    if (rst) begin
      wr_data <= 1'b0;
    end else begin
      wr_data <= taken && hwrite;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  chk_ready_high: assert property (hreadyout) else $error("slave inserted a wait state");
  chk_okay_resp: assert property (!hresp) else $error("slave gave an error response");
  chk_reset_clear: assert property (disable iff (!por_n) rst |=> gates == 4'h0 && hrdata == 32'h0
    && cell_function_sel == 3'h0) else $error("outputs not cleared by reset");
  chk_mode_delay: assert property (taken && hwrite && haddr == {20'h0, FUNCTION_OFFSET}
    |-> ##3 cell_function_sel == $past(hwdata[2:0], 2)) else $error("mode output wrong after write");
  chk_unmapped_zero: assert property (taken && !hwrite && haddr inside {[32'h2c:32'hffc]}
    |=> hrdata == 32'h0) else $error("unmapped read not zero");
  chk_sel_upper: assert property (taken && !hwrite && haddr < 32'h10 |=> hrdata[31:8] == 24'h0)
    else $error("select read upper bits not zero");
  chk_rdata_hold: assert property (!(taken && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  chk_gate_steady: assert property (disable iff (rst || !por_n)
    (!(taken && hwrite) && !wr_data && $stable(sources))[*3] |=> $stable(gates))
    else $error("gate output moved without cause");
endmodule
bind lgm_top lgm_checker #(.SOURCES(SOURCES)) u_chk (
  .mclk(mclk), .rst(rst), .por_n(por_n), .sources(sources), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .gate_one_out(gate_one_out), .gate_two_out(gate_two_out),
  .gate_three_out(gate_three_out), .gate_four_out(gate_four_out), .cell_function_sel(cell_function_sel));
`default_nettype wire

// ==== testbench.sv ====
// Purpose: register and gate matrix tests for lgm_top
// Assumes: AHB-Lite master of single word transfers
// Notes:   por_n clears configuration at start and once inside the register_access test
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lgm_pkg::*;
  logic        mclk, rst, por_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] sources, haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize, cfs;
  logic [3:0]  gates, pv;
  int          error_cnt, n_compared;
  wire logic   hready;
  assign hready = hreadyout;
  lgm_top uut (.mclk(mclk), .rst(rst), .por_n(por_n), .sources(sources), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .gate_one_out(gates[0]), .gate_two_out(gates[1]),
    .gate_three_out(gates[2]), .gate_four_out(gates[3]), .cell_function_sel(cfs));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic wrap_up;
    $display("compared %0d, wrong %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      error_cnt++;
      $display("wrong value at %0t: bus hang", $time);
      wrap_up();
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {20'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  // gate output settles one edge after a config or source change; check waits two edges
  task automatic gchk(input logic [3:0] e);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    check({28'h0, gates}, {28'h0, e});
    @(posedge mclk);
  endtask
  task automatic pulse(input logic por);
    rst   <= 1'b1;
    por_n <= !por;
    @(posedge mclk);
    rst   <= 1'b0;
    por_n <= 1'b1;
    @(posedge mclk);
  endtask
  initial begin
    rst        = 1'b1;
    por_n      = 1'b0;
    hsel       = 1'b0;
    haddr      = '0;
    htrans     = 2'b00;
    hwrite     = 1'b0;
    hsize      = 3'h2;
    hwdata     = '0;
    sources    = '0;
    error_cnt  = 0;
    n_compared = 0;
    repeat (10) @(posedge mclk);
    rst   <= 1'b0;
    por_n <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 11; i++) rdchk(12'(4 * i), 32'h0);
    $display("test power_on_values done");
    for (int g = 0; g < 4; g++) wr(12'(4 * g), 32'hffff_ff5a ^ g);
    wr(12'h030, 32'hffff_ffff);
    pulse(1'b0);
    for (int g = 0; g < 4; g++) rdchk(12'(4 * g), 32'h5a ^ g);
    rdchk(12'h030, 32'h0);
    pulse(1'b1);
    rdchk(GATE_TWO_SEL_OFFSET, 32'h0);
    $display("test register_access done");
    for (int k = 1; k < 4; k++) wr(SOURCE_ONE_OFFSET + 12'(4 * k), k);
    for (int g = 0; g < 4; g++) begin
      for (int b = 0; b < 8; b++) begin
        wr(12'(4 * g), 32'h1 << b);
        for (int k = 0; k < 2; k++) begin
          pv = k ? 4'ha : 4'h5;
          sources <= {28'h0, pv};
          // true copy at odd bits, inverted copy at even bits
          gchk((pv[b >> 1] ^ !b[0]) ? 4'(4'h1 << g) : 4'h0);
        end
      end
      wr(12'(4 * g), 32'h0);
      gchk(4'h0);
    end
    $display("test select_mapping done");
    wr(GATE_INVERT_OFFSET, 32'hf);
    gchk(4'hf);
    wr(GATE_INVERT_OFFSET, 32'hffff_fff5);
    gchk(4'h5);
    rdchk(GATE_INVERT_OFFSET, 32'h5);
    wr(GATE_STATUS_OFFSET, 32'hff);
    rdchk(GATE_STATUS_OFFSET, 32'h0);
    wr(GATE_INVERT_OFFSET, 32'h0);
    sources <= 32'h0;
    wr(GATE_ONE_SEL_OFFSET, 32'haa);
    wr(GATE_TWO_SEL_OFFSET, 32'h55);
    wr(GATE_THREE_SEL_OFFSET, 32'hff);
    gchk(4'h6);
    sources <= 32'hf;
    gchk(4'h5);
    $display("test polarity_and_or done");
    wr(SOURCE_ONE_OFFSET, 32'hffff_ffff);
    rdchk(SOURCE_ONE_OFFSET, 32'h1f);
    sources <= 32'h8000_0000;
    gchk(4'h7);
    for (int m = 0; m < 8; m++) begin
      wr(FUNCTION_OFFSET, 32'hffff_fff8 | m);
      rdchk(FUNCTION_OFFSET, m);
      check({29'h0, cfs}, m);
    end
    $display("test source_and_mode done");
    wrap_up();
  end
endmodule
`default_nettype wire
